// File: inc/mccb_pkg.sv
// What this block does
// - Converter enable powers converter, reference and bias; clear removes all three.
// - Battery bit loads the battery, routes it to converter in alt frames.
// - Boot region ends at boot-size field times 1024; field resets to one.
// - Engine clock select set gives 10 MHz, clear gives 5 MHz.
// - Engine fetches from program-base field times 1024; field comes up 0x31.
// - Bandgap chop state changes only on frame sync rising edge, per mode.
// - 00 toggles, skips at interval end, adds frame; 01/10 hold; 11 toggles.
// - Channel chop bits act only while the master current chop bit is set.
// - Each of four channel bits chops its own channel at its own location.
// - Write-only configuration bits always read back as zero.
// - Reset, wake clear enables, clock select, chop bits; battery on reset.
`default_nettype none

package mccb_pkg;

   // ****************************************************************
   // Register offsets
   // ****************************************************************
   localparam logic [15:0] ENGINE_CTRL_ADDR = 16'h2000;
   localparam logic [15:0] REF_CHOP_ADDR = 16'h2002;
   localparam logic [15:0] CONV_POWER_ADDR = 16'h2005;
   localparam logic [15:0] BATT_TEST_ADDR = 16'h2020;
   localparam logic [15:0] BOOT_LIMIT_ADDR = 16'h20a7;
   localparam logic [15:0] CODE_BASE_ADDR = 16'h20a8;
   localparam logic [15:0] CHOP_MASTER_ADDR = 16'h20ab;
   localparam logic [15:0] CHOP_AB_ADDR = 16'h20ac;
   localparam logic [15:0] CHOP_CD_ADDR = 16'h20ad;

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int FAST_CLK_BIT = 3;
   localparam int ENGINE_EN_BIT = 4;
   localparam int CHOP_MODE_LSB = 4;
   localparam int CONV_EN_BIT = 3;
   localparam int BATT_EN_BIT = 6;
   localparam int MASTER_CHOP_BIT = 0;
   localparam int CHAN_LO_BIT = 0;
   localparam int CHAN_HI_BIT = 4;

   // Every documented bit here is read/write, so no byte hides a bit.
   localparam logic [7:0] WRITE_ONLY_MASK = 8'h00;

   // ****************************************************************
   // Reset and wake values
   // ****************************************************************
   localparam logic [7:0] BOOT_SIZE_RESET = 8'h01;
   localparam logic [7:0] CODE_BASE_RESET = 8'h31;
   localparam logic [1:0] CHOP_MODE_RESET = 2'h0;

   // ****************************************************************
   // Chop modes
   // ****************************************************************
   localparam logic [1:0] CHOP_TOGGLE_ALT = 2'h0;
   localparam logic [1:0] CHOP_POSITIVE = 2'h1;
   localparam logic [1:0] CHOP_REVERSED = 2'h2;
   localparam logic [1:0] CHOP_TOGGLE = 2'h3;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int MCLK_MHZ = 40;
   localparam int ENGINE_FAST_MHZ = 10;
   localparam int ENGINE_SLOW_MHZ = 5;
   localparam logic [2:0] FAST_HALF_CYCLES =
      3'(MCLK_MHZ / (2 * ENGINE_FAST_MHZ));
   localparam logic [2:0] SLOW_HALF_CYCLES =
      3'(MCLK_MHZ / (2 * ENGINE_SLOW_MHZ));
   localparam int PAGE_SHIFT = 10;

endpackage : mccb_pkg

`default_nettype wire

// File: hdl/mccb_top.sv
`timescale 1ns/1ps
`default_nettype none

module mccb_top
   import mccb_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic wake,
   input wire logic [15:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic mux_frame_sync,
   input wire logic accumulation_interval,
   input wire logic alt_frame_active,
   output logic adc_power_enable,
   output logic vref_power_enable,
   output logic adc_bias_enable,
   output logic battery_load_enable,
   output logic battery_to_adc,
   output logic [17:0] boot_region_end,
   output logic engine_fast_clock_select,
   output logic engine_clk,
   output logic engine_run,
   output logic engine_start,
   output logic [17:0] engine_program_base,
   output logic bandgap_chop,
   output logic alternate_frame_request,
   output logic channel_a_chop,
   output logic channel_b_chop,
   output logic channel_c_chop,
   output logic channel_d_chop
);

   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      logic fast_clk;
      logic engine_en;
      logic [1:0] chop_mode;
      logic conv_en;
      logic batt_en;
      logic [7:0] boot_size;
      logic [7:0] code_base;
      logic master_chop;
      logic [3:0] chan_bits;
      logic [3:0] chan_chop;
      logic [7:0] rdata;
      logic sync_prev;
      logic chop_state;
      logic alt_req;
      logic batt_adc;
      logic [2:0] div_cnt;
      logic eng_clk;
      logic eng_start;
   } mccb_state_t;

   localparam mccb_state_t STATE_RESET = '{
      fast_clk: 1'b0,
      engine_en: 1'b0,
      chop_mode: CHOP_MODE_RESET,
      conv_en: 1'b0,
      batt_en: 1'b0,
      boot_size: BOOT_SIZE_RESET,
      code_base: CODE_BASE_RESET,
      master_chop: 1'b0,
      chan_bits: 4'h0,
      chan_chop: 4'h0,
      rdata: 8'h00,
      sync_prev: 1'b0,
      chop_state: 1'b0,
      alt_req: 1'b0,
      batt_adc: 1'b0,
      div_cnt: 3'h0,
      eng_clk: 1'b0,
      eng_start: 1'b0
   };

   mccb_state_t st;
   mccb_state_t next_st;

   // ****************************************************************
   // Helpers
   // ****************************************************************

   // Both address outputs scale a page number to a byte address.
   function automatic logic [17:0] page_to_addr(input logic [7:0] page);
      page_to_addr = {page, 10'h000};
   endfunction : page_to_addr

   function automatic logic [7:0] read_value(input logic [15:0] addr,
                                             input mccb_state_t s);
      logic [7:0] v;
      v = 8'h00;
      case (addr)
         ENGINE_CTRL_ADDR: begin
            v[FAST_CLK_BIT] = s.fast_clk;
            v[ENGINE_EN_BIT] = s.engine_en;
         end
         REF_CHOP_ADDR: begin
            v[CHOP_MODE_LSB +: 2] = s.chop_mode;
         end
         CONV_POWER_ADDR: begin
            v[CONV_EN_BIT] = s.conv_en;
         end
         BATT_TEST_ADDR: begin
            v[BATT_EN_BIT] = s.batt_en;
         end
         BOOT_LIMIT_ADDR: begin
            v = s.boot_size;
         end
         CODE_BASE_ADDR: begin
            v = s.code_base;
         end
         CHOP_MASTER_ADDR: begin
            v[MASTER_CHOP_BIT] = s.master_chop;
         end
         CHOP_AB_ADDR: begin
            v[CHAN_LO_BIT] = s.chan_bits[0];
            v[CHAN_HI_BIT] = s.chan_bits[1];
         end
         CHOP_CD_ADDR: begin
            v[CHAN_LO_BIT] = s.chan_bits[2];
            v[CHAN_HI_BIT] = s.chan_bits[3];
         end
         default: begin
            v = 8'h00;
         end
      endcase
      // Hidden bits never leak what software last wrote.
      read_value = v & ~WRITE_ONLY_MASK;
   endfunction : read_value

   // ****************************************************************
   // Next state
   // ****************************************************************
   logic sync_rise;
   logic [2:0] half_cycles;

   always_comb begin
      next_st = st;
      sync_rise = mux_frame_sync & ~st.sync_prev;
      half_cycles = st.fast_clk ? FAST_HALF_CYCLES : SLOW_HALF_CYCLES;

      // Register writes.
      if (reg_wr) begin
         case (reg_addr)
            ENGINE_CTRL_ADDR: begin
               next_st.fast_clk = reg_wdata[FAST_CLK_BIT];
               next_st.engine_en = reg_wdata[ENGINE_EN_BIT];
            end
            REF_CHOP_ADDR: begin
               next_st.chop_mode = reg_wdata[CHOP_MODE_LSB +: 2];
            end
            CONV_POWER_ADDR: begin
               next_st.conv_en = reg_wdata[CONV_EN_BIT];
            end
            BATT_TEST_ADDR: begin
               next_st.batt_en = reg_wdata[BATT_EN_BIT];
            end
            BOOT_LIMIT_ADDR: begin
               next_st.boot_size = reg_wdata;
            end
            CODE_BASE_ADDR: begin
               next_st.code_base = reg_wdata;
            end
            CHOP_MASTER_ADDR: begin
               next_st.master_chop = reg_wdata[MASTER_CHOP_BIT];
            end
            CHOP_AB_ADDR: begin
               next_st.chan_bits[0] = reg_wdata[CHAN_LO_BIT];
               next_st.chan_bits[1] = reg_wdata[CHAN_HI_BIT];
            end
            CHOP_CD_ADDR: begin
               next_st.chan_bits[2] = reg_wdata[CHAN_LO_BIT];
               next_st.chan_bits[3] = reg_wdata[CHAN_HI_BIT];
            end
            default: begin
            end
         endcase
      end

      // Read data stand only in the cycle after the strobe.
      next_st.rdata = reg_rd ? read_value(reg_addr, st) : 8'h00;

      // Wake overrides a write in the same cycle. The battery bit is
      // left alone: its value after wake is not defined, and keeping it
      // avoids dropping a running battery test.
      if (wake) begin
         next_st.fast_clk = 1'b0;
         next_st.engine_en = 1'b0;
         next_st.chop_mode = CHOP_MODE_RESET;
         next_st.conv_en = 1'b0;
         next_st.boot_size = BOOT_SIZE_RESET;
         next_st.code_base = CODE_BASE_RESET;
         next_st.master_chop = 1'b0;
         next_st.chan_bits = 4'h0;
      end

      // Bandgap chop moves only on a frame sync rising edge.
      next_st.sync_prev = mux_frame_sync;
      next_st.alt_req = 1'b0;
      if (sync_rise) begin
         case (st.chop_mode)
            CHOP_TOGGLE_ALT: begin
               // The closing frame keeps its polarity and gets an extra
               // alternative frame instead.
               if (accumulation_interval) begin
                  next_st.alt_req = 1'b1;
               end else begin
                  next_st.chop_state = ~st.chop_state;
               end
            end
            CHOP_POSITIVE: begin
               next_st.chop_state = 1'b0;
            end
            CHOP_REVERSED: begin
               next_st.chop_state = 1'b1;
            end
            CHOP_TOGGLE: begin
               next_st.chop_state = ~st.chop_state;
            end
            default: begin
               next_st.chop_state = st.chop_state;
            end
         endcase
      end

      // Channel chop is gated by the master bit.
      next_st.chan_chop = st.master_chop ? st.chan_bits : 4'h0;

      // Battery goes to the converter only during alternative frames.
      next_st.batt_adc = st.batt_en & alt_frame_active;

      // Engine clock divider. It holds low while the engine is halted so
      // the engine always restarts on a clean first edge. A select change
      // mid-period finishes the shorter half at once rather than
      // overrunning.
      if (st.engine_en) begin
         if (st.div_cnt >= half_cycles - 3'h1) begin
            next_st.div_cnt = 3'h0;
            next_st.eng_clk = ~st.eng_clk;
         end else begin
            next_st.div_cnt = st.div_cnt + 3'h1;
         end
      end else begin
         next_st.div_cnt = 3'h0;
         next_st.eng_clk = 1'b0;
      end

      // One pulse when the engine goes from halted to running.
      next_st.eng_start = next_st.engine_en & ~st.engine_en;
   end

   // ****************************************************************
   // Registers
   // ****************************************************************
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         st <= STATE_RESET;
      end else begin
         st <= next_st;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign reg_rdata = st.rdata;
   assign adc_power_enable = st.conv_en;
   assign vref_power_enable = st.conv_en;
   assign adc_bias_enable = st.conv_en;
   assign battery_load_enable = st.batt_en;
   assign battery_to_adc = st.batt_adc;
   assign boot_region_end = page_to_addr(st.boot_size);
   assign engine_fast_clock_select = st.fast_clk;
   assign engine_clk = st.eng_clk;
   assign engine_run = st.engine_en;
   assign engine_start = st.eng_start;
   assign engine_program_base = page_to_addr(st.code_base);
   assign bandgap_chop = st.chop_state;
   assign alternate_frame_request = st.alt_req;
   assign channel_a_chop = st.chan_chop[0];
   assign channel_b_chop = st.chan_chop[1];
   assign channel_c_chop = st.chan_chop[2];
   assign channel_d_chop = st.chan_chop[3];

endmodule : mccb_top

`default_nettype wire

// File: verification/mccb_chk.sv
`timescale 1ns/1ps
`default_nettype none

module mccb_chk
   import mccb_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic wake,
   input wire logic [15:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic mux_frame_sync,
   input wire logic accumulation_interval,
   input wire logic alt_frame_active,
   input wire logic adc_power_enable,
   input wire logic vref_power_enable,
   input wire logic adc_bias_enable,
   input wire logic battery_load_enable,
   input wire logic battery_to_adc,
   input wire logic [17:0] boot_region_end,
   input wire logic engine_fast_clock_select,
   input wire logic engine_clk,
   input wire logic engine_run,
   input wire logic engine_start,
   input wire logic [17:0] engine_program_base,
   input wire logic bandgap_chop,
   input wire logic alternate_frame_request,
   input wire logic channel_a_chop,
   input wire logic channel_b_chop,
   input wire logic channel_c_chop,
   input wire logic channel_d_chop
);
   // ****************************************************************
   // Shadow of the chop mode and master bit, seen from the bus
   // ****************************************************************
   logic [1:0] mode;
   logic mst;
   logic wr_ok;
   assign wr_ok = reg_wr && !wake;

   always_ff @(posedge mclk) begin
      if (!rst_b || wake) begin
         mode <= 2'h0;
         mst <= 1'b0;
      end else if (reg_wr) begin
         if (reg_addr == REF_CHOP_ADDR) mode <= reg_wdata[5:4];
         if (reg_addr == CHOP_MASTER_ADDR) mst <= reg_wdata[0];
      end
   end

   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);

   a_conv_power: assert property (
      wr_ok && reg_addr == CONV_POWER_ADDR |=>
      {adc_power_enable, vref_power_enable, adc_bias_enable} ==
      {3{$past(reg_wdata[3])}}) else $error("converter power wrong");
   a_batt_load: assert property (
      wr_ok && reg_addr == BATT_TEST_ADDR |=>
      battery_load_enable == $past(reg_wdata[6]))
      else $error("battery load wrong");
   a_batt_route: assert property (
      battery_to_adc == $past(battery_load_enable && alt_frame_active))
      else $error("battery routing wrong");
   a_boot_end: assert property (
      wr_ok && reg_addr == BOOT_LIMIT_ADDR |=>
      boot_region_end == {$past(reg_wdata), 10'h000})
      else $error("boot end wrong");
   a_code_base: assert property (
      wr_ok && reg_addr == CODE_BASE_ADDR |=>
      engine_program_base == {$past(reg_wdata), 10'h000})
      else $error("program base wrong");
   a_fast_half: assert property (
      $rose(engine_clk) && engine_fast_clock_select |=>
      (engine_clk || !engine_run) ##1
      (!engine_clk || !engine_run || !engine_fast_clock_select))
      else $error("fast half period wrong");
   a_slow_half: assert property (
      $rose(engine_clk) && !engine_fast_clock_select |=>
      (engine_clk || !engine_run || engine_fast_clock_select)[*3])
      else $error("slow half period short");
   a_clk_idle: assert property (
      !engine_run && !$past(engine_run) |-> !engine_clk)
      else $error("engine clock runs while halted");
   a_start_pulse: assert property (
      engine_start == $rose(engine_run)) else $error("start pulse wrong");
   a_chop_edge: assert property (
      $changed(bandgap_chop) |->
      $past(mux_frame_sync) && !$past(mux_frame_sync, 2))
      else $error("chop changed off sync edge");
   a_chop_hold: assert property (
      $rose(mux_frame_sync) && mode[0] != mode[1] |=>
      bandgap_chop == $past(mode[1])) else $error("chop hold wrong");
   a_chop_toggle: assert property (
      $rose(mux_frame_sync) && (mode == CHOP_TOGGLE ||
      mode == CHOP_TOGGLE_ALT && !accumulation_interval) |=>
      bandgap_chop != $past(bandgap_chop) && !alternate_frame_request)
      else $error("chop toggle wrong");
   a_alt_insert: assert property (
      $rose(mux_frame_sync) && mode == CHOP_TOGGLE_ALT &&
      accumulation_interval |=> alternate_frame_request &&
      $stable(bandgap_chop) ##1 !alternate_frame_request)
      else $error("alternate frame wrong");
   a_chan_gate: assert property (
      !$past(mst) |-> !(channel_a_chop || channel_b_chop ||
      channel_c_chop || channel_d_chop)) else $error("chop ungated");

   c_start: cover property (engine_start);
   c_alt: cover property (alternate_frame_request);
   c_chan: cover property (channel_d_chop);
   c_batt: cover property ($rose(battery_to_adc));
endmodule : mccb_chk

bind mccb_top mccb_chk chk (.*);

`default_nettype wire

// File: verification/mccb_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) cmp(18'(g), 18'(e))

module testbench
   import mccb_pkg::*;
;
   logic mclk = 1'b0, rst_b = 1'b0, wake = 1'b0;
   logic reg_wr = 1'b0, reg_rd = 1'b0, mux_frame_sync = 1'b0;
   logic accumulation_interval = 1'b0, alt_frame_active = 1'b0;
   logic [15:0] reg_addr = 16'h0000;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] reg_rdata;
   logic adc_power_enable, vref_power_enable, adc_bias_enable;
   logic battery_load_enable, battery_to_adc, engine_fast_clock_select;
   logic engine_clk, engine_run, engine_start, bandgap_chop;
   logic alternate_frame_request, channel_a_chop, channel_b_chop;
   logic channel_c_chop, channel_d_chop;
   logic [17:0] boot_region_end, engine_program_base;
   logic [15:0] ra [9] = '{ENGINE_CTRL_ADDR, REF_CHOP_ADDR,
      CONV_POWER_ADDR, BATT_TEST_ADDR, BOOT_LIMIT_ADDR, CODE_BASE_ADDR,
      CHOP_MASTER_ADDR, CHOP_AB_ADDR, CHOP_CD_ADDR};
   logic [7:0] rm [9] = '{8'h18, 8'h30, 8'h08, 8'h40, 8'hff, 8'hff,
      8'h01, 8'h11, 8'h11};
   int errors = 0, checked = 0, cyc = 0, p;

   mccb_top uut (.*);

   always #12.5 mclk = ~mclk;

   // ****************************************************************
   // Bus and checking tasks
   // ****************************************************************
   task cmp(input logic [17:0] g, input logic [17:0] e);
      checked++;
      if (g !== e) begin
         errors++;
         $display("ERROR %0t: got %h expected %h", $time, g, e);
      end
   endtask : cmp

   task tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : tick

   task wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
      #1;
   endtask : wr

   task rd(input logic [15:0] a, input logic [7:0] e);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      `CHK(reg_rdata, e);
   endtask : rd

   task pulse(input logic a);
      @(posedge mclk);
      mux_frame_sync <= 1'b1;
      accumulation_interval <= a;
      @(posedge mclk);
      mux_frame_sync <= 1'b0;
      #1;
   endtask : pulse

   // Period from one rising edge of the engine clock to the next.
   task per(output int n);
      int k;
      n = 0;
      for (int i = 0; i < 4; i++) begin
         k = 0;
         while (engine_clk !== i[0] && k < 40) begin
            tick(1);
            k++;
         end
         if (i > 1) n += k;
      end
   endtask : per

   function automatic logic [7:0] rval(logic [15:0] a, logic [7:0] b);
      if (a == BOOT_LIMIT_ADDR) return 8'h01;
      if (a == CODE_BASE_ADDR) return 8'h31;
      return (a == BATT_TEST_ADDR) ? b : 8'h00;
   endfunction : rval

   task report_and_stop;
      $display("Comparisons %0d, errors %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : report_and_stop

   always @(posedge mclk) begin
      cyc++;
      if (cyc == 4000) begin
         errors++;
         $display("ERROR %0t: timeout", $time);
         report_and_stop;
      end
   end

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   initial begin
      repeat (10) @(posedge mclk);
      rst_b <= 1'b1;
      #1;
      `CHK(boot_region_end, 18'h00400);
      `CHK(engine_program_base, 18'h0c400);
      foreach (ra[i]) rd(ra[i], rval(ra[i], 8'h00));
      wr(16'h2001, 8'hff);
      rd(16'h2001, 8'h00);
      foreach (ra[i]) wr(ra[i], 8'hff);
      tick(2);
      `CHK({adc_power_enable, vref_power_enable, adc_bias_enable},
         3'h7);
      `CHK(battery_load_enable, 1'b1);
      `CHK(engine_fast_clock_select, 1'b1);
      `CHK(boot_region_end, 18'h3fc00);
      `CHK(engine_program_base, 18'h3fc00);
      `CHK({channel_a_chop, channel_b_chop, channel_c_chop,
         channel_d_chop}, 4'hf);
      foreach (ra[i]) rd(ra[i], rm[i]);
      per(p);
      per(p);
      `CHK(p, 4);
      @(posedge mclk);
      alt_frame_active <= 1'b1;
      tick(2);
      `CHK(battery_to_adc, 1'b1);
      alt_frame_active <= 1'b0;
      wr(CONV_POWER_ADDR, 8'h00);
      `CHK({adc_power_enable, vref_power_enable, adc_bias_enable},
         3'h0);
      `CHK(battery_to_adc, 1'b0);
      wr(CHOP_MASTER_ADDR, 8'h00);
      tick(1);
      `CHK({channel_a_chop, channel_b_chop, channel_c_chop,
         channel_d_chop}, 4'h0);
      wr(CHOP_AB_ADDR, 8'h10);
      wr(CHOP_MASTER_ADDR, 8'h01);
      tick(1);
      `CHK({channel_a_chop, channel_b_chop, channel_c_chop,
         channel_d_chop}, 4'h7);
      wr(REF_CHOP_ADDR, 8'h20);
      pulse(1'b0);
      `CHK(bandgap_chop, 1'b1);
      wr(REF_CHOP_ADDR, 8'h10);
      tick(3);
      `CHK(bandgap_chop, 1'b1);
      pulse(1'b0);
      `CHK(bandgap_chop, 1'b0);
      wr(REF_CHOP_ADDR, 8'h30);
      pulse(1'b0);
      `CHK(bandgap_chop, 1'b1);
      pulse(1'b1);
      `CHK({bandgap_chop, alternate_frame_request}, 2'h0);
      wr(REF_CHOP_ADDR, 8'h00);
      pulse(1'b0);
      `CHK({bandgap_chop, alternate_frame_request}, 2'h2);
      pulse(1'b1);
      `CHK({bandgap_chop, alternate_frame_request}, 2'h3);
      tick(1);
      `CHK(alternate_frame_request, 1'b0);
      wr(ENGINE_CTRL_ADDR, 8'h00);
      tick(2);
      `CHK(engine_clk, 1'b0);
      wr(ENGINE_CTRL_ADDR, 8'h10);
      `CHK({engine_start, engine_run}, 2'h3);
      tick(1);
      `CHK(engine_start, 1'b0);
      per(p);
      per(p);
      `CHK(p, 8);
      @(posedge mclk);
      wake <= 1'b1;
      reg_addr <= CODE_BASE_ADDR;
      reg_wdata <= 8'h55;
      reg_wr <= 1'b1;
      @(posedge mclk);
      wake <= 1'b0;
      reg_wr <= 1'b0;
      #1;
      `CHK({engine_run, engine_fast_clock_select, adc_power_enable,
         battery_load_enable}, 4'h1);
      foreach (ra[i]) rd(ra[i], rval(ra[i], 8'h40));
      `CHK(engine_program_base, 18'h0c400);
      report_and_stop;
   end
endmodule : testbench

`default_nettype wire
